// File: pfr_defs.svh
// pfr_defs.svh: offsets, field positions and reset values of the force/init/reload selector
`ifndef PFR_DEFS_SVH
`define PFR_DEFS_SVH

// register offsets (word index on the plain register port)
`define PFR_SUBMODULE_CONTROL_TWO_ADDR        4'h0
`define PFR_STATUS_ADDR       4'h1

// control-two field positions
`define PFR_PAIR_A_INIT_BIT   12
`define PFR_PAIR_B_INIT_BIT   11
`define PFR_AUX_INIT_BIT      10
`define PFR_INIT_SEL_HI       9
`define PFR_INIT_SEL_LO       8
`define PFR_FORCE_INIT_ENABLE_BIT         7
`define PFR_FORCE_BIT         6
`define PFR_FORCE_SEL_HI      5
`define PFR_FORCE_SEL_LO      3
`define PFR_RELOAD_SEL_BIT    2

// reset value and writable mask (bit 6 is write-one self-clearing, reads zero)
`define PFR_SUBMODULE_CONTROL_TWO_RESET       16'h0000
`define PFR_SUBMODULE_CONTROL_TWO_WMASK       16'h1FBC

`endif

// File: pfr_pkg.sv
// pfr_pkg.sv: types of the force/init/reload selector
`default_nettype none
package pfr_pkg;
    // initialization source codes
    typedef enum logic [1:0] {
        PFR_INIT_LOCAL_SYNC    = 2'h0,
        PFR_INIT_MASTER_RELOAD = 2'h1,
        PFR_INIT_MASTER_SYNC   = 2'h2,
        PFR_INIT_RESERVED      = 2'h3
    } pfr_init_sel_t;

    // force source codes
    typedef enum logic [2:0] {
        PFR_FRC_SOFTWARE       = 3'h0,
        PFR_FRC_MASTER_FORCE   = 3'h1,
        PFR_FRC_LOCAL_RELOAD   = 3'h2,
        PFR_FRC_MASTER_RELOAD  = 3'h3,
        PFR_FRC_LOCAL_SYNC     = 3'h4,
        PFR_FRC_MASTER_SYNC    = 3'h5,
        PFR_FRC_EXTERNAL       = 3'h6,
        PFR_FRC_RESERVED       = 3'h7
    } pfr_force_sel_t;

    // event pulses arriving from this submodule and from submodule 0
    typedef struct packed {
        logic local_sync;
        logic local_reload;
        logic master_sync;
        logic master_reload;
        logic master_force;
    } pfr_events_t;
endpackage
`default_nettype wire

// File: pfr_top.sv
// pfr_top.sv: init, force and reload source selection of one modulator submodule
//
// The implementer's own choices: the address map and the address-and-strobe port.
`include "pfr_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module pfr_top
#(
    parameter int SM_INDEX  = 1,   // position of this submodule; 0 is the master
    parameter int CNT_WIDTH = 16   // width of the counter and initial-count value
)
(
    // clock and reset
    input  wire logic                 CLK_SYS_IN,
    input  wire logic                 RESETN_IN,
    // register port
    input  wire logic [3:0]           ADDR_IN,
    input  wire logic [15:0]          WDATA_IN,
    input  wire logic                 WR_IN,
    input  wire logic                 RD_IN,
    output logic      [15:0]          RDATA_OUT,
    // event inputs
    input  wire pfr_pkg::pfr_events_t EVENTS_IN,
    input  wire logic                 EXTERNAL_FORCE_INPUT_IN,
    input  wire logic                 LOAD_OKAY_BIT_IN,
    input  wire logic [CNT_WIDTH-1:0] INIT_COUNT_IN,
    // deadtime source field values chosen for each pair on force
    input  wire logic [1:0]           PAIR_A_SOURCE_FIELD_IN,
    input  wire logic [1:0]           PAIR_B_SOURCE_FIELD_IN,
    // outputs to counter and pins
    output logic                      FORCE_OUT,
    output logic                      INIT_OUT,
    output logic [CNT_WIDTH-1:0]      INIT_VALUE_OUT,
    output logic                      RELOAD_OUT,
    output logic                      PRIMARY_OUTPUT_OUT,
    output logic                      SECONDARY_OUTPUT_OUT,
    output logic                      PAIR_A_LEVEL_OUT,
    output logic                      PAIR_B_LEVEL_OUT,
    output logic                      AUX_OUTPUT_OUT
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (SM_INDEX < 0 || CNT_WIDTH < 1 || CNT_WIDTH > 32)
    begin : g_bad_param
        $error("pfr_top: parameter out of range");
    end

    localparam logic IS_MASTER = (SM_INDEX == 0);  // master submodule gates master sources

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    logic [15:0]             submodule_control_two_reg;      // control-two storage
    logic                    sw_force_reg;   // one-cycle software force pulse
    pfr_pkg::pfr_init_sel_t  init_sel;       // init source field
    pfr_pkg::pfr_force_sel_t force_sel;      // force source field
    logic                    force_init_enable;          // force init enable
    logic                    reload_sel;     // reload source select
    logic                    force_next;     // selected force event
    logic                    init_next;      // selected init event
    logic                    reload_next;    // selected reload event
    logic                    wr_submodule_control_two;       // write to control-two

    assign wr_submodule_control_two   = WR_IN && (ADDR_IN == `PFR_SUBMODULE_CONTROL_TWO_ADDR);
    assign init_sel   = pfr_pkg::pfr_init_sel_t'(submodule_control_two_reg[`PFR_INIT_SEL_HI:`PFR_INIT_SEL_LO]);
    assign force_sel  = pfr_pkg::pfr_force_sel_t'(submodule_control_two_reg[`PFR_FORCE_SEL_HI:`PFR_FORCE_SEL_LO]);
    assign force_init_enable      = submodule_control_two_reg[`PFR_FORCE_INIT_ENABLE_BIT];
    assign reload_sel = submodule_control_two_reg[`PFR_RELOAD_SEL_BIT];

    // stores writable fields; force bit is never stored
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            submodule_control_two_reg <= `PFR_SUBMODULE_CONTROL_TWO_RESET;
        else if (wr_submodule_control_two)
            submodule_control_two_reg <= WDATA_IN & `PFR_SUBMODULE_CONTROL_TWO_WMASK;
    end

    // writing one to the force bit makes a single pulse
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            sw_force_reg <= 1'b0;
        else
            sw_force_reg <= wr_submodule_control_two && WDATA_IN[`PFR_FORCE_BIT];
    end

    // ------------------------------------------------------------
    // source selection
    // ------------------------------------------------------------
    // force origin picked by the force source field
    always_comb
    begin
        case (force_sel)
            pfr_pkg::PFR_FRC_SOFTWARE:      force_next = sw_force_reg;
            pfr_pkg::PFR_FRC_MASTER_FORCE:  force_next = !IS_MASTER && EVENTS_IN.master_force;
            pfr_pkg::PFR_FRC_LOCAL_RELOAD:  force_next = EVENTS_IN.local_reload;
            pfr_pkg::PFR_FRC_MASTER_RELOAD: force_next = !IS_MASTER && EVENTS_IN.master_reload;
            pfr_pkg::PFR_FRC_LOCAL_SYNC:    force_next = EVENTS_IN.local_sync;
            pfr_pkg::PFR_FRC_MASTER_SYNC:   force_next = !IS_MASTER && EVENTS_IN.master_sync;
            pfr_pkg::PFR_FRC_EXTERNAL:      force_next = EXTERNAL_FORCE_INPUT_IN;
            default:                        force_next = 1'b0;  // reserved code
        endcase
    end

    // counter init source, with the force path overriding when enabled
    always_comb
    begin
        case (init_sel)
            pfr_pkg::PFR_INIT_LOCAL_SYNC:    init_next = EVENTS_IN.local_sync;
            pfr_pkg::PFR_INIT_MASTER_RELOAD: init_next = !IS_MASTER && EVENTS_IN.master_reload;
            pfr_pkg::PFR_INIT_MASTER_SYNC:   init_next = !IS_MASTER && EVENTS_IN.master_sync;
            default:                         init_next = 1'b0;  // reserved code
        endcase
        if (force_init_enable && force_next)
            init_next = 1'b1;
    end

    // reload source; master path ignores the local load-okay bit
    always_comb
    begin
        if (reload_sel)
            reload_next = !IS_MASTER && EVENTS_IN.master_reload;
        else
            reload_next = EVENTS_IN.local_reload && LOAD_OKAY_BIT_IN;
    end

    // ------------------------------------------------------------
    // event outputs
    // ------------------------------------------------------------
    // registered event pulses
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            FORCE_OUT  <= 1'b0;
            INIT_OUT   <= 1'b0;
            RELOAD_OUT <= 1'b0;
        end
        else
        begin
            FORCE_OUT  <= force_next;
            INIT_OUT   <= init_next;
            RELOAD_OUT <= reload_next;
        end
    end

    // initial-count value handed to the counter on a forced init
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            INIT_VALUE_OUT <= '0;
        else if (force_init_enable && force_next)
            INIT_VALUE_OUT <= INIT_COUNT_IN;
    end

    // ------------------------------------------------------------
    // pin levels
    // ------------------------------------------------------------
    // pins take initial levels on init; force applies deadtime source values
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            PRIMARY_OUTPUT_OUT   <= 1'b0;
            SECONDARY_OUTPUT_OUT <= 1'b0;
            PAIR_A_LEVEL_OUT     <= 1'b0;
            PAIR_B_LEVEL_OUT     <= 1'b0;
            AUX_OUTPUT_OUT       <= 1'b0;
        end
        else
        begin
            if (force_next)
            begin
                PRIMARY_OUTPUT_OUT   <= PAIR_A_SOURCE_FIELD_IN[0];
                SECONDARY_OUTPUT_OUT <= PAIR_B_SOURCE_FIELD_IN[0];
            end
            if (init_next)
            begin
                PAIR_A_LEVEL_OUT <= submodule_control_two_reg[`PFR_PAIR_A_INIT_BIT];
                PAIR_B_LEVEL_OUT <= submodule_control_two_reg[`PFR_PAIR_B_INIT_BIT];
                AUX_OUTPUT_OUT   <= submodule_control_two_reg[`PFR_AUX_INIT_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    // read data one cycle after the strobe, zero elsewhere and for unmapped
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            RDATA_OUT <= 16'h0000;
        else if (RD_IN && ADDR_IN == `PFR_SUBMODULE_CONTROL_TWO_ADDR)
            RDATA_OUT <= submodule_control_two_reg;
        else if (RD_IN && ADDR_IN == `PFR_STATUS_ADDR)
            RDATA_OUT <= {11'h000, AUX_OUTPUT_OUT, PAIR_B_LEVEL_OUT, PAIR_A_LEVEL_OUT,
                          SECONDARY_OUTPUT_OUT, PRIMARY_OUTPUT_OUT};
        else
            RDATA_OUT <= 16'h0000;
    end

endmodule

`default_nettype wire

// File: pfr_sib_model.sv
// pfr_sib_model.sv: sibling submodules and external force source
`timescale 1ns/100ps
`default_nettype none
module pfr_sib_model
(
    // pulse requests from the bench
    input  wire logic [5:0]          fire_in,
    // pulses towards the submodule
    output var pfr_pkg::pfr_events_t ev_out,
    output var logic                 ext_out
);
    // pulses stand only in the requested cycle and fall back low after it
    assign ev_out  = pfr_pkg::pfr_events_t'(fire_in[4:0]);
    assign ext_out = fire_in[5];
endmodule
`default_nettype wire

// File: pfr_top_sva.sv
// pfr_top_sva.sv: port assertions of the force/init/reload selector
`include "pfr_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module pfr_top_sva
#(
    parameter int CNT_WIDTH = 16 // counter width, as in the design
)
(
    // clock, reset and register writes
    input wire logic                 CLK_SYS_IN,
    input wire logic                 RESETN_IN,
    input wire logic [3:0]           ADDR_IN,
    input wire logic [15:0]          WDATA_IN,
    input wire logic                 WR_IN,
    // events in, selected events and levels out
    input wire pfr_pkg::pfr_events_t EVENTS_IN,
    input wire logic                 EXTERNAL_FORCE_INPUT_IN,
    input wire logic [CNT_WIDTH-1:0] INIT_COUNT_IN,
    input wire logic                 FORCE_OUT,
    input wire logic                 INIT_OUT,
    input wire logic [CNT_WIDTH-1:0] INIT_VALUE_OUT,
    input wire logic                 RELOAD_OUT,
    input wire logic                 PAIR_B_LEVEL_OUT,
    input wire logic                 AUX_OUTPUT_OUT
);
    logic [15:0] ctl_reg; // shadow of control two, taken from the write strobe
    // shadow follows every write to control two
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            ctl_reg <= 16'h0000;
        else if (WR_IN && ADDR_IN == `PFR_SUBMODULE_CONTROL_TWO_ADDR)
            ctl_reg <= WDATA_IN;
    end
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RESETN_IN);
    // counter init that a force carries with it
    sequence s_init_ld; INIT_OUT && INIT_VALUE_OUT == INIT_COUNT_IN; endsequence
    property p_frc_lrl; ctl_reg[5:3] == 3'h2 && EVENTS_IN.local_reload |=> FORCE_OUT; endproperty
    a_frc_lrl: assert property (p_frc_lrl) else $error("no force on local reload");
    property p_frc_lsy; ctl_reg[5:3] == 3'h4 && EVENTS_IN.local_sync |=> FORCE_OUT; endproperty
    a_frc_lsy: assert property (p_frc_lsy) else $error("no force on local sync");
    property p_frc_ext; ctl_reg[5:3] == 3'h6 && EXTERNAL_FORCE_INPUT_IN |=> FORCE_OUT; endproperty
    a_frc_ext: assert property (p_frc_ext) else $error("no force on external input");
    property p_frc_rsv; ctl_reg[5:3] == 3'h7 |=> !FORCE_OUT; endproperty
    a_frc_rsv: assert property (p_frc_rsv) else $error("force on reserved code");
    property p_frc_init; FORCE_OUT && $past(ctl_reg[7]) |-> s_init_ld; endproperty
    a_frc_init: assert property (p_frc_init) else $error("force did not load counter");
    // levels come from the control bits that stood when the init was selected
    property p_lvl;
        INIT_OUT |-> PAIR_B_LEVEL_OUT == $past(ctl_reg[11]) && AUX_OUTPUT_OUT == $past(ctl_reg[10]);
    endproperty
    a_lvl: assert property (p_lvl) else $error("init levels wrong");
    property p_init_ls; ctl_reg[9:8] == 2'h0 && EVENTS_IN.local_sync |=> INIT_OUT; endproperty
    a_init_ls: assert property (p_init_ls) else $error("no init on local sync");
    property p_rld_mst; ctl_reg[2] |=> RELOAD_OUT == $past(EVENTS_IN.master_reload); endproperty
    a_rld_mst: assert property (p_rld_mst) else $error("reload not from master");
endmodule
bind pfr_top pfr_top_sva #(.CNT_WIDTH(CNT_WIDTH)) u_sva
(
    .CLK_SYS_IN(CLK_SYS_IN), .RESETN_IN(RESETN_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN),
    .EVENTS_IN(EVENTS_IN), .EXTERNAL_FORCE_INPUT_IN(EXTERNAL_FORCE_INPUT_IN), .INIT_COUNT_IN(INIT_COUNT_IN),
    .FORCE_OUT(FORCE_OUT), .INIT_OUT(INIT_OUT), .INIT_VALUE_OUT(INIT_VALUE_OUT), .RELOAD_OUT(RELOAD_OUT),
    .PAIR_B_LEVEL_OUT(PAIR_B_LEVEL_OUT), .AUX_OUTPUT_OUT(AUX_OUTPUT_OUT)
);
`default_nettype wire

// File: tb_top.sv
// tb_top.sv: self-checking bench of the force/init/reload selector
`include "pfr_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    // ------------------------------
    // stimulus and observed signals
    // ------------------------------
    logic                 clk, rst_n, wr, rd, lok, ext, frc, ini, rld, pri, sec, pal, pbl, aux;
    logic [3:0]           addr;
    logic [15:0]          wdata, rdata, icnt, ival;
    logic [5:0]           fire; // {external, events} pulse requests
    logic [1:0]           pa;   // levels offered for the forced pins
    pfr_pkg::pfr_events_t ev;
    int                   n_fail = 0, comparisons = 0, cyc = 0;
    pfr_top #(.SM_INDEX(1), .CNT_WIDTH(16)) dut
    (
        .CLK_SYS_IN(clk), .RESETN_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
        .RDATA_OUT(rdata), .EVENTS_IN(ev), .EXTERNAL_FORCE_INPUT_IN(ext), .LOAD_OKAY_BIT_IN(lok),
        .INIT_COUNT_IN(icnt), .PAIR_A_SOURCE_FIELD_IN(pa), .PAIR_B_SOURCE_FIELD_IN(~pa), .FORCE_OUT(frc),
        .INIT_OUT(ini), .INIT_VALUE_OUT(ival), .RELOAD_OUT(rld), .PRIMARY_OUTPUT_OUT(pri),
        .SECONDARY_OUTPUT_OUT(sec), .PAIR_A_LEVEL_OUT(pal), .PAIR_B_LEVEL_OUT(pbl), .AUX_OUTPUT_OUT(aux)
    );
    pfr_sib_model sib (.fire_in(fire), .ev_out(ev), .ext_out(ext));
    // compare one value and count it
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one-cycle write and read strobes; read data stand in the next cycle
    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk) {addr, rd} <= {a, 1'b1};
        @(posedge clk) rd <= 1'b0;
        #1 chk("rdata", e, rdata);
    endtask
    // program control two, request one set of far-side pulses, stop after the answer
    task automatic pulse(input logic [15:0] cfg, input logic [5:0] v);
        reg_wr(4'h0, cfg);
        @(posedge clk) fire <= v;
        @(posedge clk) fire <= 6'h00;
        #1;
    endtask
    task automatic t_regs();
        reg_rd(4'h0, `PFR_SUBMODULE_CONTROL_TWO_RESET);
        reg_wr(4'h0, 16'hFFFF);
        reg_rd(4'h0, 16'h1FBC);
        reg_wr(4'hF, 16'h0000);
        reg_rd(4'h0, 16'h1FBC);
        reg_rd(4'hF, 16'h0000);
    endtask
    // every force source code with its own event, init enabled
    task automatic t_force();
        logic [5:0] tab [8];
        logic [2:0] c;
        tab = '{6'h00, 6'h01, 6'h08, 6'h02, 6'h10, 6'h04, 6'h20, 6'h3F};
        for (int i = 0; i < 8; i++)
        begin
            c = 3'(i);
            @(posedge clk) pa <= c[1:0];
            if (c == 3'h0)
            begin
                // software force: pulse comes one cycle after the write lands
                reg_wr(4'h0, {3'h0, c[2], c[0], c[1], 2'h3, 1'b1, 1'b1, c, 3'h0});
                @(posedge clk);
                #1;
            end
            else
                pulse({3'h0, c[2], c[0], c[1], 2'h3, 1'b1, 1'b0, c, 3'h0}, tab[i]);
            chk("force", 16'(c != 3'h7), 16'(frc));
            chk("init", 16'(c != 3'h7), 16'(ini));
            if (c != 3'h7)
            begin
                chk("ival", icnt, ival);
                chk("pins", {14'h0, c[0], ~c[0]}, {14'h0, pri, sec});
                chk("levels", {14'h0, c[0], c[1]}, {14'h0, pbl, aux});
                chk("pair a level", 16'(c[2]), 16'(pal));
                reg_rd(4'h1, {11'h000, c[1], c[0], c[2], ~c[0], c[0]});
            end
        end
    endtask
    // force with init disabled leaves the counter alone
    task automatic t_nofrcen();
        pulse(16'h0330, 6'h20);
        chk("force", 16'h0001, 16'(frc));
        chk("init", 16'h0000, 16'(ini));
    endtask
    // init sources 00, 01, 10 with forcing parked on the reserved code
    task automatic t_init();
        logic [5:0] tab [3];
        tab = '{6'h10, 6'h02, 6'h04};
        for (int i = 0; i < 3; i++)
        begin
            pulse({6'h00, 2'(i), 8'h38}, tab[i]);
            chk("init", 16'h0001, 16'(ini));
            chk("force", 16'h0000, 16'(frc));
        end
    endtask
    // local reload, then master reload with the local load-okay dropped
    task automatic t_reload();
        pulse(16'h0338, 6'h08);
        chk("reload", 16'h0001, 16'(rld));
        @(posedge clk) lok <= 1'b0;
        pulse(16'h033C, 6'h08);
        chk("reload", 16'h0000, 16'(rld));
        pulse(16'h033C, 6'h02);
        chk("reload", 16'h0001, 16'(rld));
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // clock and hang guard
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_fail++;
            print_verdict();
        end
    end
    // reset for six cycles, then the scenarios
    initial
    begin
        {rst_n, wr, rd, fire, pa, addr, wdata} = '0;
        {lok, icnt} = {1'b1, 16'hA5C3};
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_force();
        t_nofrcen();
        t_init();
        t_reload();
        print_verdict();
    end
endmodule
`default_nettype wire
